// ===== include/usb_glue_defs.svh
// register offsets, field positions and reset values of the usb function glue
`ifndef USB_GLUE_DEFS_SVH
`define USB_GLUE_DEFS_SVH
// What this block does
// - in flags at usb 0x02, out flags at 0x04, common flags at 0x06
// - matching enables at usb 0x07, 0x09 and 0x0B
// - function address 0x00, power 0x01, frame number low/high 0x0C and 0x0D
// - endpoint index register at 0x0E, clock recovery control at 0x0F
// - endpoint zero control/status at indexed 0x11, received byte count at 0x16
// - selected in endpoint control/status high byte at 0x12, plus a low byte
// - selected out endpoint control/status low/high at 0x14 and 0x15
// - selected out endpoint packet count high at 0x17, plus a low byte
// - one kilobyte of ram serves as endpoint fifo space
// - unused fifo ram stays usable as general data memory
// - an avalon access to fifo space waits two extra cycles; the cpu data-memory port adds none
// - with the enable bit set, data addresses 0x0400-0x07FF map to fifo ram
// - with the enable bit set, ordinary data memory there is blocked
// - writing one to the usb reset-source flag enables usb as reset source
// - enabled source plus bus reset while controller enabled causes system reset
// - enabled source plus vbus matching selected polarity causes system reset
// - flag reads one after usb reset; external reset pin untouched
// - bit0 at sfr 0xE7 gates vbus level interrupt; bits 7-1 read zero
// - bit0 at sfr 0xF7 selects vbus interrupt priority, one is high
// - index low nibble picks endpoint 0-3, 4-F reserved, upper bits zero
// - controller starts inhibited; cleared by software, reset sets it again

// usb indirect register offsets
`define UA_FUNC_ADDR 8'h00
`define UA_POWER 8'h01
`define UA_INFLG 8'h02
`define UA_OUTFLG 8'h04
`define UA_CMFLG 8'h06
`define UA_INEN 8'h07
`define UA_OUTEN 8'h09
`define UA_CMEN 8'h0B
`define UA_FRML 8'h0C
`define UA_FRMH 8'h0D
`define UA_EP_INDEX 8'h0E
`define UA_CLKRC 8'h0F
`define UA_E0CS 8'h11
`define UA_INCSL 8'h10
`define UA_INCSH 8'h12
`define UA_OUTCSL 8'h14
`define UA_OUTCSH 8'h15
`define UA_EP0_CNT 8'h16
`define UA_OUTCNTL 8'h13
`define UA_OUTCNTH 8'h17
`define UA_FIFO0 8'h20
`define UA_FIFO3 8'h23
// sfr style offsets
`define SA_XIRQ_EN 8'hE7
`define SA_XIRQ_PRI 8'hF7
// avalon byte addresses of the slave
`define AV_USB_ADDR 12'h000
`define AV_USB_DATA 12'h004
`define AV_XIRQ_EN 12'h008
`define AV_XIRQ_PRI 12'h00C
`define AV_RST_SRC 12'h010
`define AV_REGCTL 12'h014
`define AV_EMICF 12'h018
`define AV_STATUS 12'h01C
`define AV_FIFO_BASE 12'h400
// fields
`define POWER_INHIBIT 4
`define POWER_USBRST 3
`define RST_USBFLAG 7
`define REG_VBUS_POL 6
`define EMI_FAE 6
// reset values
`define POWER_RST 8'h10
`define ZERO8 8'h00
// xram window
`define FIFO_LO 16'h0400
`define FIFO_HI 16'h07FF
// extra wait for fifo-space moves, in ns at 100 MHz
`define FIFO_EXTRA_NS 20
`define CLK_NS 10
`define FIFO_EXTRA_CYC ((`FIFO_EXTRA_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== include/usb_glue_pkg.sv
// types of the usb function glue
package usb_glue_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] power;
    logic [7:0] in_flg;
    logic [7:0] out_flg;
    logic [7:0] cm_flg;
    logic [7:0] in_en;
    logic [7:0] out_en;
    logic [7:0] cm_en;
    logic [15:0] frame;
    logic [3:0] ep_index;
    logic [7:0] clk_recov;
    logic [7:0] e0cs;
    logic [7:0] ep0_cnt;
    logic [3:0][7:0] incsl;
    logic [3:0][7:0] incsh;
    logic [3:0][7:0] outcsl;
    logic [3:0][7:0] outcsh;
    logic [3:0][7:0] outcntl;
    logic [3:0][7:0] outcnth;
    logic [7:0] uaddr;
    logic xirq_en;
    logic xirq_pri;
    logic rst_en;
    logic rst_flag;
    logic vbus_pol;
    logic fae;
    logic [1:0] wait_cnt;
    logic busy;
    logic [31:0] rdata;
    logic sys_reset;
  } glue_state_t;

  typedef struct packed {
    logic [1:0] ep;
    logic in_set;
    logic out_set;
    logic [7:0] cm_set;
    logic [7:0] count;
  } usb_event_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xram_req_t;
endpackage

// ===== verilog/usb_function_system_glue.sv
// usb function glue: indirect register map, fifo ram, reset source, vbus irq
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`include "usb_glue_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module usb_function_system_glue
  import usb_glue_pkg::*;
#(
  parameter int RAM_BYTES = 1024
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // avalon-mm slave
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // cpu data-memory port
  input wire xram_req_t xram_req_in,
  output logic [7:0] xram_rdata_out,
  output logic xram_is_fifo_out,
  output logic xram_block_out,
  // usb core events
  input wire usb_event_t usb_event_in,
  input wire logic usb_frame_strobe_in,
  input wire logic [10:0] usb_frame_in,
  input wire logic usb_bus_reset_in,
  input wire logic vbus_pin_in,
  // system side
  output logic usb_enabled_out,
  output logic usb_core_reset_out,
  output logic vbus_irq_out,
  output logic vbus_irq_high_out,
  output logic system_reset_out
);

  ////////////////////////////////////////////////////////////////
  // state, ram and pin synchronisers
  glue_state_t s_r, s_nxt;
  logic [7:0] ram [RAM_BYTES];
  logic [2:0] vbus_sync_r, brst_sync_r;
  logic vbus_lvl_r, brst_lvl_r;
  logic [7:0] ram_q_r;
  logic [9:0] fifo_ptr_r [4];

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vbus_sync_r <= 3'h0;
      brst_sync_r <= 3'h0;
      vbus_lvl_r <= 1'b0;
      brst_lvl_r <= 1'b0;
    end else begin
      vbus_sync_r <= {vbus_sync_r[1:0], vbus_pin_in};
      brst_sync_r <= {brst_sync_r[1:0], usb_bus_reset_in};
      if (vbus_sync_r[2] == vbus_sync_r[1]) begin
        vbus_lvl_r <= vbus_sync_r[2];
      end
      if (brst_sync_r[2] == brst_sync_r[1]) begin
        brst_lvl_r <= brst_sync_r[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // decode
  logic bus_req, is_fifo_x, fifo_port_acc;
  logic [1:0] ep, port_ep;
  logic [7:0] wb, rb;
  logic [9:0] ram_addr;
  logic ram_we;
  logic [7:0] ram_wd;

  assign ep = s_r.ep_index[1:0];
  assign bus_req = avs_read_in | avs_write_in;
  assign wb = avs_writedata_in[7:0];
  assign is_fifo_x = s_r.fae && xram_req_in.addr >= `FIFO_LO && xram_req_in.addr <= `FIFO_HI;
  assign port_ep = s_r.uaddr[1:0];
  assign fifo_port_acc = avs_address_in == `AV_USB_DATA && s_r.uaddr >= `UA_FIFO0
    && s_r.uaddr <= `UA_FIFO3;

  always_comb begin
    ram_we = 1'b0;
    ram_wd = wb;
    ram_addr = fifo_ptr_r[port_ep];
    if (is_fifo_x) begin
      ram_addr = xram_req_in.addr[9:0];
      ram_we = xram_req_in.wr;
      ram_wd = xram_req_in.wdata;
    end else if (avs_address_in >= `AV_FIFO_BASE) begin
      ram_addr = avs_address_in[9:0];
      ram_we = avs_write_in && avs_byteenable_in[0] && s_r.busy && s_r.wait_cnt == 2'h0;
    end else if (fifo_port_acc) begin
      ram_we = avs_write_in && avs_byteenable_in[0] && !s_r.busy;
    end
  end

  // fifo ram, one kilobyte
  always_ff @(posedge clock_in) begin
    if (ram_we) begin
      ram[ram_addr] <= ram_wd;
    end
    ram_q_r <= ram[ram_addr];
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        fifo_ptr_r[i] <= 10'h000;
      end
    end else if (fifo_port_acc && bus_req && s_r.busy && s_r.wait_cnt == 2'h0 && !is_fifo_x) begin
      fifo_ptr_r[port_ep] <= fifo_ptr_r[port_ep] + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // usb register read mux
  always_comb begin
    rb = `ZERO8;
    unique case (s_r.uaddr)
      `UA_FUNC_ADDR: rb = s_r.addr;
      `UA_POWER: rb = s_r.power;
      `UA_INFLG: rb = s_r.in_flg;
      `UA_OUTFLG: rb = s_r.out_flg;
      `UA_CMFLG: rb = s_r.cm_flg;
      `UA_INEN: rb = s_r.in_en;
      `UA_OUTEN: rb = s_r.out_en;
      `UA_CMEN: rb = s_r.cm_en;
      `UA_FRML: rb = s_r.frame[7:0];
      `UA_FRMH: rb = s_r.frame[15:8];
      `UA_EP_INDEX: rb = {4'h0, s_r.ep_index};
      `UA_CLKRC: rb = s_r.clk_recov;
      `UA_E0CS: rb = s_r.e0cs;
      `UA_INCSL: rb = s_r.incsl[ep];
      `UA_INCSH: rb = s_r.incsh[ep];
      `UA_OUTCSL: rb = s_r.outcsl[ep];
      `UA_OUTCSH: rb = s_r.outcsh[ep];
      `UA_EP0_CNT: rb = s_r.ep0_cnt;
      `UA_OUTCNTL: rb = s_r.outcntl[ep];
      `UA_OUTCNTH: rb = s_r.outcnth[ep];
      default: rb = `ZERO8;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.sys_reset = 1'b0;
    // hardware events: frame number latched on the strobe; flag sets follow the clears below
    if (usb_frame_strobe_in) begin
      s_nxt.frame = {5'h00, usb_frame_in};
    end
    // bus access
    if (bus_req && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.wait_cnt = (avs_address_in >= `AV_FIFO_BASE || fifo_port_acc) ? 2'(`FIFO_EXTRA_CYC) : 2'h0;
      s_nxt.rdata = 32'h0;
      unique case (avs_address_in)
        `AV_USB_ADDR: s_nxt.rdata = {24'h0, s_r.uaddr};
        `AV_USB_DATA: begin
          s_nxt.rdata = {24'h0, rb};
          if (avs_read_in && s_r.uaddr == `UA_INFLG) s_nxt.in_flg = `ZERO8;
          if (avs_read_in && s_r.uaddr == `UA_OUTFLG) s_nxt.out_flg = `ZERO8;
          if (avs_read_in && s_r.uaddr == `UA_CMFLG) s_nxt.cm_flg = `ZERO8;
        end
        `AV_XIRQ_EN: s_nxt.rdata = {31'h0, s_r.xirq_en};
        `AV_XIRQ_PRI: s_nxt.rdata = {31'h0, s_r.xirq_pri};
        `AV_RST_SRC: s_nxt.rdata = {24'h0, s_r.rst_flag, 7'h00};
        `AV_REGCTL: s_nxt.rdata = {24'h0, 1'b0, s_r.vbus_pol, 6'h00};
        `AV_EMICF: s_nxt.rdata = {24'h0, 1'b0, s_r.fae, 6'h00};
        `AV_STATUS: s_nxt.rdata = {29'h0, vbus_lvl_r, brst_lvl_r, ~s_r.power[`POWER_INHIBIT]};
        default: s_nxt.rdata = 32'h0;
      endcase
      if (avs_write_in && avs_byteenable_in[0]) begin
        unique case (avs_address_in)
          `AV_USB_ADDR: s_nxt.uaddr = wb;
          `AV_XIRQ_EN: s_nxt.xirq_en = wb[0];
          `AV_XIRQ_PRI: s_nxt.xirq_pri = wb[0];
          `AV_RST_SRC: s_nxt.rst_en = wb[`RST_USBFLAG];
          `AV_REGCTL: s_nxt.vbus_pol = wb[`REG_VBUS_POL];
          `AV_EMICF: s_nxt.fae = wb[`EMI_FAE];
          `AV_USB_DATA: begin
            unique case (s_r.uaddr)
              `UA_FUNC_ADDR: s_nxt.addr = {1'b0, wb[6:0]};
              `UA_POWER: begin
                s_nxt.power = {wb[7:5], s_r.power[`POWER_INHIBIT] & wb[`POWER_INHIBIT], wb[3:0]};
                if (wb[`POWER_USBRST]) s_nxt.power[`POWER_INHIBIT] = 1'b1;
              end
              `UA_INEN: s_nxt.in_en = wb;
              `UA_OUTEN: s_nxt.out_en = wb;
              `UA_CMEN: s_nxt.cm_en = wb;
              `UA_EP_INDEX: s_nxt.ep_index = wb[3:0];
              `UA_CLKRC: s_nxt.clk_recov = wb;
              `UA_E0CS: s_nxt.e0cs = wb;
              `UA_INCSL: s_nxt.incsl[ep] = wb;
              `UA_INCSH: s_nxt.incsh[ep] = wb;
              `UA_OUTCSL: s_nxt.outcsl[ep] = wb;
              `UA_OUTCSH: s_nxt.outcsh[ep] = wb;
              default: s_nxt.addr = s_nxt.addr;
            endcase
          end
          default: s_nxt.uaddr = s_nxt.uaddr;
        endcase
      end
    end else if (s_r.busy && s_r.wait_cnt != 2'h0) begin
      s_nxt.wait_cnt = s_r.wait_cnt - 2'h1;
      // ram output has settled by the last wait cycle
      if (s_r.wait_cnt == 2'h1 && (avs_address_in >= `AV_FIFO_BASE || fifo_port_acc)) begin
        s_nxt.rdata = {24'h0, ram_q_r};
      end
    end else if (s_r.busy) begin
      s_nxt.busy = 1'b0;
    end
    // event sets after clears so sets win
    if (usb_event_in.in_set) s_nxt.in_flg[usb_event_in.ep] = 1'b1;
    if (usb_event_in.out_set) s_nxt.out_flg[usb_event_in.ep] = 1'b1;
    s_nxt.cm_flg = s_nxt.cm_flg | usb_event_in.cm_set;
    if (usb_event_in.out_set) begin
      if (usb_event_in.ep == 2'h0) s_nxt.ep0_cnt = usb_event_in.count;
      else s_nxt.outcntl[usb_event_in.ep] = usb_event_in.count;
    end
    // usb reset source
    if (s_r.rst_en && ((brst_lvl_r && !s_r.power[`POWER_INHIBIT]) || vbus_lvl_r == s_r.vbus_pol)) begin
      s_nxt.sys_reset = 1'b1;
      s_nxt.rst_flag = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_r <= '0;
      s_r.power <= `POWER_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign avs_waitrequest_out = bus_req && !(s_r.busy && s_r.wait_cnt == 2'h0);
  assign avs_readdata_out = s_r.rdata;
  assign xram_rdata_out = ram_q_r;
  assign xram_is_fifo_out = is_fifo_x;
  assign xram_block_out = is_fifo_x;
  assign usb_enabled_out = ~s_r.power[`POWER_INHIBIT];
  assign usb_core_reset_out = s_r.power[`POWER_USBRST];
  assign vbus_irq_out = s_r.xirq_en & (vbus_lvl_r == s_r.vbus_pol);
  assign vbus_irq_high_out = s_r.xirq_pri;
  assign system_reset_out = s_r.sys_reset;
endmodule
`default_nettype wire

// ===== bench/usb_glue_monitor.sv
// port checker of the usb function glue
`include "usb_glue_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module usb_glue_monitor
  import usb_glue_pkg::*;
(
  // watched ports
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire xram_req_t xram_req_in,
  input wire logic xram_is_fifo_out,
  input wire logic xram_block_out,
  input wire logic usb_enabled_out,
  input wire logic usb_core_reset_out,
  input wire logic vbus_irq_high_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  fifo_map_a: assert property (xram_is_fifo_out |-> xram_req_in.addr >= `FIFO_LO && xram_req_in.addr <= `FIFO_HI)
    else $error("fifo hit outside window");
  block_map_a: assert property (xram_block_out |-> xram_req_in.addr >= `FIFO_LO && xram_req_in.addr <= `FIFO_HI)
    else $error("block outside window");
  fifo_wait_a: assert property ($rose(avs_read_in) && avs_address_in[10] |-> avs_waitrequest_out [*2])
    else $error("fifo access too fast");
  answer_bound_a: assert property ((avs_read_in || avs_write_in) |-> ##[0:10] !avs_waitrequest_out)
    else $error("no answer");
  upper_zero_a: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  prio_cause_a: assert property (!$stable(vbus_irq_high_out) |-> $past(avs_write_in)
    && $past(avs_address_in) == `AV_XIRQ_PRI)
    else $error("priority changed without write");
  enable_cause_a: assert property ($rose(usb_enabled_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
    else $error("enabled without write");
  inhibit_cause_a: assert property ($fell(usb_enabled_out) |-> usb_core_reset_out || $past(usb_core_reset_out))
    else $error("inhibit without usb reset");
endmodule
bind usb_function_system_glue usb_glue_monitor u_mon (.clock_in, .arst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .xram_req_in, .xram_is_fifo_out, .xram_block_out,
  .usb_enabled_out, .usb_core_reset_out, .vbus_irq_high_out);
`default_nettype wire

// ===== bench/usb_core_model.sv
// usb core stand-in: event pulses, frames, bus levels
`timescale 1ns/1ps
`default_nettype none
module usb_core_model
  import usb_glue_pkg::*;
(
  // clock
  input wire logic clock_in,
  // toward the glue
  output usb_event_t usb_event_out,
  output logic usb_frame_strobe_out,
  output logic [10:0] usb_frame_out,
  output logic usb_bus_reset_out,
  output logic vbus_pin_out
);
  initial begin
    usb_event_out = '0;
    usb_frame_strobe_out = 1'b0;
    usb_frame_out = 11'h000;
    usb_bus_reset_out = 1'b0;
    vbus_pin_out = 1'b0;
  end
  // one-cycle in event, only on clock edges
  task automatic in_event(input logic [1:0] ep);
    @(posedge clock_in);
    usb_event_out.ep <= ep;
    usb_event_out.in_set <= 1'b1;
    @(posedge clock_in);
    usb_event_out <= '0;
  endtask
  task automatic out_event(input logic [1:0] ep, input logic [7:0] n);
    @(posedge clock_in);
    usb_event_out.ep <= ep;
    usb_event_out.out_set <= 1'b1;
    usb_event_out.count <= n;
    @(posedge clock_in);
    usb_event_out <= '0;
  endtask
  task automatic frame(input logic [10:0] n);
    @(posedge clock_in);
    usb_frame_out <= n;
    usb_frame_strobe_out <= 1'b1;
    @(posedge clock_in);
    usb_frame_strobe_out <= 1'b0;
  endtask
  task automatic level(input logic br, input logic vb);
    @(posedge clock_in);
    usb_bus_reset_out <= br;
    vbus_pin_out <= vb;
  endtask
endmodule
`default_nettype wire

// ===== bench/usb_function_system_glue_tb_top.sv
// self-checking bench of the usb function glue
`include "usb_glue_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module usb_function_system_glue_tb_top
  import usb_glue_pkg::*;
;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [11:0] av_addr = '0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = '0;
  logic [31:0] av_rdata, r, v;
  logic av_wait, is_fifo, blocked, enabled, core_rst, irq, irq_high, sys_rst, fstb, brst, vbus;
  logic [7:0] x_rdata;
  logic [10:0] frm;
  xram_req_t xreq = '0;
  usb_event_t ev;
  logic [31:0] seed = 32'h0000002F;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] rw [5] = '{8'h00, 8'h07, 8'h09, 8'h0B, 8'h0F};
  logic [7:0] ix [2] = '{8'h12, 8'h15};
  logic [16:0] win [4] = '{17'h107FF, 17'h00800, 17'h003FF, 17'h10400};
  initial forever #5 clock_in = ~clock_in;
  usb_function_system_glue u_dut (.clock_in, .arst_n_in, .avs_address_in(av_addr), .avs_read_in(av_rd),
    .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(av_rdata),
    .avs_waitrequest_out(av_wait), .xram_req_in(xreq), .xram_rdata_out(x_rdata), .xram_is_fifo_out(is_fifo),
    .xram_block_out(blocked), .usb_event_in(ev), .usb_frame_strobe_in(fstb), .usb_frame_in(frm),
    .usb_bus_reset_in(brst), .vbus_pin_in(vbus), .usb_enabled_out(enabled), .usb_core_reset_out(core_rst),
    .vbus_irq_out(irq), .vbus_irq_high_out(irq_high), .system_reset_out(sys_rst));
  usb_core_model u_core (.clock_in, .usb_event_out(ev), .usb_frame_strobe_out(fstb), .usb_frame_out(frm),
    .usb_bus_reset_out(brst), .vbus_pin_out(vbus));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= w;
    av_rd <= !w;
    @(posedge clock_in);
    while (av_wait) @(posedge clock_in);
    r = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  task automatic uw(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, `AV_USB_ADDR, {24'h0, a});
    bus(1'b1, `AV_USB_DATA, {24'h0, d});
  endtask
  task automatic ur(input logic [7:0] a);
    bus(1'b1, `AV_USB_ADDR, {24'h0, a});
    bus(1'b0, `AV_USB_DATA, 32'h0);
  endtask
  task automatic xram(input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    xreq <= '{rd: rd, wr: wr, addr: a, wdata: d};
    @(posedge clock_in);
    xreq <= '0;
    #1;
  endtask
  task automatic wait_reset();
    n = 0;
    while (sys_rst !== 1'b1 && n < 30) begin
      @(posedge clock_in);
      n++;
    end
  endtask
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clock_in);
    arst_n_in <= 1'b1;
    ur(`UA_POWER);
    chk(r, 32'h10);
    bus(1'b0, `AV_XIRQ_EN, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, `AV_XIRQ_PRI, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, 12'h020, 32'h0);
    chk(r, 32'h0);
    foreach (rw[i]) begin
      v = xs() & 32'hFF;
      uw(rw[i], v[7:0]);
      ur(rw[i]);
      chk(r, rw[i] == `UA_FUNC_ADDR ? v & 32'h7F : v);
    end
    u_core.frame(11'h5A3);
    ur(`UA_FRML);
    chk(r, 32'hA3);
    ur(`UA_FRMH);
    chk(r, 32'h05);
    uw(`UA_EP_INDEX, 8'hF3);
    ur(`UA_EP_INDEX);
    chk(r, 32'h03);
    foreach (ix[i]) begin
      v = xs() & 32'hFF;
      uw(`UA_EP_INDEX, 8'h02);
      uw(ix[i], v[7:0]);
      uw(`UA_EP_INDEX, 8'h01);
      uw(ix[i], ~v[7:0]);
      uw(`UA_EP_INDEX, 8'h02);
      ur(ix[i]);
      chk(r, v);
    end
    u_core.in_event(2'd1);
    ur(`UA_INFLG);
    chk(r, 32'h02);
    ur(`UA_INFLG);
    chk(r, 32'h0);
    v = xs() & 32'hFF;
    u_core.out_event(2'd0, v[7:0]);
    ur(`UA_EP0_CNT);
    chk(r, v);
    uw(`UA_EP_INDEX, 8'h02);
    u_core.out_event(2'd2, ~v[7:0]);
    ur(`UA_OUTCNTL);
    chk(r, {24'h0, ~v[7:0]});
    ur(`UA_OUTFLG);
    chk(r, 32'h05);
    bus(1'b1, `AV_REGCTL, 32'h40);
    bus(1'b1, `AV_XIRQ_EN, 32'hFF);
    bus(1'b0, `AV_XIRQ_EN, 32'h0);
    chk(r, 32'h1);
    u_core.level(1'b0, 1'b1);
    repeat (8) @(posedge clock_in);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, `AV_XIRQ_EN, 32'h0);
    repeat (2) @(posedge clock_in);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, `AV_XIRQ_PRI, 32'h1);
    @(posedge clock_in);
    chk({31'h0, irq_high}, 32'h1);
    u_core.level(1'b0, 1'b0);
    bus(1'b1, `AV_EMICF, 32'h40);
    v = xs() & 32'hFF;
    xram(1'b0, 1'b1, 16'h0455, v[7:0]);
    bus(1'b0, 12'h455, 32'h0);
    chk(r, v);
    xram(1'b0, 1'b1, 16'h07F0, ~v[7:0]);
    xram(1'b1, 1'b0, 16'h07F0, 8'h00);
    chk({24'h0, x_rdata}, {24'h0, ~v[7:0]});
    v = xs() & 32'hFF;
    uw(8'h21, v[7:0]);
    bus(1'b0, `AV_FIFO_BASE, 32'h0);
    chk(r, v);
    ur(`UA_FIFO0);
    chk(r, v);
    foreach (win[i]) begin
      @(posedge clock_in);
      xreq.addr <= win[i][15:0];
      #1;
      chk({31'h0, is_fifo}, {31'h0, win[i][16]});
      chk({31'h0, blocked}, {31'h0, win[i][16]});
    end
    bus(1'b1, `AV_EMICF, 32'h0);
    #1;
    chk({31'h0, is_fifo}, 32'h0);
    bus(1'b1, `AV_RST_SRC, 32'h80);
    uw(`UA_POWER, 8'h00);
    repeat (2) @(posedge clock_in);
    chk({31'h0, enabled}, 32'h1);
    u_core.level(1'b1, 1'b0);
    wait_reset();
    chk({31'h0, sys_rst}, 32'h1);
    u_core.level(1'b0, 1'b0);
    repeat (8) @(posedge clock_in);
    bus(1'b0, `AV_RST_SRC, 32'h0);
    chk(r, 32'h80);
    u_core.level(1'b0, 1'b1);
    wait_reset();
    chk({31'h0, sys_rst}, 32'h1);
    u_core.level(1'b0, 1'b0);
    uw(`UA_POWER, 8'h08);
    repeat (3) @(posedge clock_in);
    chk({31'h0, enabled}, 32'h0);
    chk({31'h0, core_rst}, 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
